// ### hdl/ssi_cfg.svh
// constants for the simplex sideband initialization glue
`ifndef SSI_CFG_SVH
`define SSI_CFG_SVH

// ==========================================
// clock and structure
`define SSI_CLK_MHZ 20
`define SSI_LANES 2
`define SSI_LOOP_W 3
`define SSI_CNT_W 24

// ==========================================
// reconfiguration port
`define SSI_DRP_AW 9
`define SSI_DRP_DW 16
`define SSI_DRP_DEPTH 16
`define SSI_DRP_IW 4
`define SSI_DRP_RST 16'h0000

// ==========================================
// timed initialization intervals
`define SSI_ALIGN_TIME_US 100
`define SSI_ALIGN_CYC (`SSI_ALIGN_TIME_US * `SSI_CLK_MHZ)
`define SSI_BOND_TIME_US 50
`define SSI_BOND_CYC (`SSI_BOND_TIME_US * `SSI_CLK_MHZ)
`define SSI_VERIFY_TIME_US 150
`define SSI_VERIFY_CYC (`SSI_VERIFY_TIME_US * `SSI_CLK_MHZ)
`define SSI_REINIT_TIME_MS 10
`define SSI_REINIT_CYC (`SSI_REINIT_TIME_MS * 1000 * `SSI_CLK_MHZ)
`define SSI_WDOG_TIME_US 1000
`define SSI_WDOG_CYC (`SSI_WDOG_TIME_US * `SSI_CLK_MHZ)

// ==========================================
// back channel message latency
`define SSI_BC_TIME_NS 500
`define SSI_BC_CYC ((`SSI_BC_TIME_NS * `SSI_CLK_MHZ) / 1000)
`define SSI_BC_W 8

`endif

// ### hdl/ssi_pkg.sv
// types shared by both ends of the simplex sideband initialization glue
package ssi_pkg;

   // ==========================================
   // one set of sideband initialization indications
   typedef struct packed {
      logic reset;
      logic verify;
      logic bonded;
      logic aligned;
   } ssi_sideband_t;

   // ==========================================
   // bring-up and reconfiguration controller states
   typedef enum logic [1:0] {SND_RESET, SND_ALIGNED, SND_BONDED, SND_VERIFY} ssi_send_state_t;
   typedef enum logic [2:0] {RCV_RESET, RCV_ALIGNED, RCV_BONDED, RCV_VERIFY, RCV_READY} ssi_recv_state_t;

   typedef enum logic {DRPC_IDLE, DRPC_WAIT} ssi_drpc_state_t;

endpackage

// ### hdl/ssi_link_if.sv
// carrier between the documented end and the back channel / reconfiguration end
`include "ssi_cfg.svh"

interface ssi_link_if (
   input wire logic core_clk,
   input wire logic arst_n
);
   // receive side indications, driven by the device
   ssi_pkg::ssi_sideband_t rxSb;
   // forwarded indications into the transmit side
   ssi_pkg::ssi_sideband_t txSbIn;
   // reconfiguration port
   logic [`SSI_DRP_AW-1:0] drpAddr;
   logic [`SSI_DRP_DW-1:0] drpDi;
   logic drpEn;
   logic drpWe;
   logic [`SSI_DRP_DW-1:0] drpDo;
   logic drpRdy;

   modport dev (
      input core_clk, arst_n, txSbIn, drpAddr, drpDi, drpEn, drpWe,
      output rxSb, drpDo, drpRdy
   );

   modport far (
      input core_clk, arst_n, rxSb, drpDo, drpRdy,
      output txSbIn, drpAddr, drpDi, drpEn, drpWe
   );
endinterface

// ### hdl/ssi_dev_end.sv
// simplex sideband initialization, transceiver status/control and reconfiguration slave
// Operation
// - each side exposes aligned, bonded, verify, reset
// - bonded used only with several lanes
// - back channel forwards receive states to transmit
// - back channel messages on every sideband change
// - three timers drive aligned, bonded, verify
// - timed indications change only on expiry
// - receive watchdog falls back to reset
// - timed transmit side re-initializes periodically
// - watchdog duration set by timeout parameter
// - power-down input passed to transceiver
// - three-bit loopback select to transceiver
// - ready marks write done or read valid
// - controller drives port synchronously to clock
// - transmit and receive reset-done reported separately
// - lock output shows PLL lock
`include "ssi_cfg.svh"

module ssi_dev_end #(
   parameter logic [`SSI_CNT_W-1:0] REINIT_CYCLES = `SSI_CNT_W'(`SSI_REINIT_CYC),
   parameter logic [`SSI_CNT_W-1:0] WATCHDOG_TIMEOUT = `SSI_CNT_W'(`SSI_WDOG_CYC)
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // sideband and reconfiguration link
   ssi_link_if.dev link,
   // initialization control and status
   input wire logic backChannelMode,
   input wire logic rxLaneAligned,
   input wire logic rxLaneBonded,
   input wire logic rxLaneVerified,
   output ssi_pkg::ssi_sideband_t txSb,
   output logic rxReady,
   // transceiver control
   input wire logic powerDown,
   input wire logic [`SSI_LOOP_W-1:0] loopback,
   output logic xcvrPowerDown,
   output logic [`SSI_LOOP_W-1:0] xcvrLoopback,
   // transceiver status
   input wire logic xcvrTxResetDone,
   input wire logic xcvrRxResetDone,
   input wire logic xcvrPllLock,
   output logic txResetDone,
   output logic rxResetDone,
   output logic txLock
);
   localparam bit MULTI = (`SSI_LANES > 1);

   // ==========================================
   // send side bring-up
   ssi_pkg::ssi_send_state_t sndState, next_sndState;
   logic [`SSI_CNT_W-1:0] sndCnt, next_sndCnt;
   logic [`SSI_CNT_W-1:0] reinitCnt, next_reinitCnt;
   logic sndHold, next_sndHold;
   ssi_pkg::ssi_sideband_t next_txSb;

   // timer mode walks the states; back-channel mode follows the forwarded set
   always_comb begin
      next_sndState = sndState;
      next_sndCnt = sndCnt + 1'h1;
      next_reinitCnt = reinitCnt + 1'h1;
      next_sndHold = sndHold;
      if (backChannelMode) begin
         next_reinitCnt = '0;
         if (link.txSbIn.reset) begin
            next_sndHold = 1'h0;
         end
         if (sndHold || link.txSbIn.reset) begin
            next_sndState = ssi_pkg::SND_RESET;
         end else if (link.txSbIn.verify) begin
            next_sndState = ssi_pkg::SND_VERIFY;
         end else if (link.txSbIn.bonded && MULTI) begin
            next_sndState = ssi_pkg::SND_BONDED;
         end else if (link.txSbIn.aligned) begin
            next_sndState = ssi_pkg::SND_ALIGNED;
         end else begin
            next_sndState = ssi_pkg::SND_RESET;
         end
         if (next_sndState != sndState || next_sndState == ssi_pkg::SND_RESET ||
             next_sndState == ssi_pkg::SND_VERIFY) begin
            next_sndCnt = '0;
         end
         // stuck half way: drop to reset until the far side restarts
         if ((sndState == ssi_pkg::SND_ALIGNED || sndState == ssi_pkg::SND_BONDED) &&
             sndCnt == WATCHDOG_TIMEOUT - 1'h1) begin
            next_sndState = ssi_pkg::SND_RESET;
            next_sndHold = 1'h1;
            next_sndCnt = '0;
         end
      end else begin
         next_sndHold = 1'h0;
         if (reinitCnt == REINIT_CYCLES - 1'h1) begin
            next_reinitCnt = '0;
            next_sndState = ssi_pkg::SND_RESET;
            next_sndCnt = '0;
         end else begin
            case (sndState)
               ssi_pkg::SND_RESET: begin
                  if (sndCnt == `SSI_CNT_W'(`SSI_ALIGN_CYC - 1)) begin
                     next_sndState = ssi_pkg::SND_ALIGNED;
                     next_sndCnt = '0;
                  end
               end
               ssi_pkg::SND_ALIGNED: begin
                  if (MULTI && sndCnt == `SSI_CNT_W'(`SSI_BOND_CYC - 1)) begin
                     next_sndState = ssi_pkg::SND_BONDED;
                     next_sndCnt = '0;
                  end else if (!MULTI && sndCnt == `SSI_CNT_W'(`SSI_VERIFY_CYC - 1)) begin
                     next_sndState = ssi_pkg::SND_VERIFY;
                     next_sndCnt = '0;
                  end
               end
               ssi_pkg::SND_BONDED: begin
                  if (sndCnt == `SSI_CNT_W'(`SSI_VERIFY_CYC - 1)) begin
                     next_sndState = ssi_pkg::SND_VERIFY;
                     next_sndCnt = '0;
                  end
               end
               ssi_pkg::SND_VERIFY: begin
                  next_sndCnt = sndCnt; // held until the next period
               end
               default: begin
                  next_sndState = ssi_pkg::SND_RESET;
                  next_sndCnt = '0;
               end
            endcase
         end
      end
      // indications move only with the state, so only on expiry in timer mode
      next_txSb.reset = (next_sndState == ssi_pkg::SND_RESET);
      next_txSb.aligned = (next_sndState != ssi_pkg::SND_RESET);
      next_txSb.bonded = MULTI && (next_sndState == ssi_pkg::SND_BONDED ||
                                   next_sndState == ssi_pkg::SND_VERIFY);
      next_txSb.verify = (next_sndState == ssi_pkg::SND_VERIFY);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sndState <= ssi_pkg::SND_RESET;
         sndCnt <= '0;
         reinitCnt <= '0;
         sndHold <= 1'h0;
         txSb <= 4'h8; // reset indication only
      end else begin
         sndState <= next_sndState;
         sndCnt <= next_sndCnt;
         reinitCnt <= next_reinitCnt;
         sndHold <= next_sndHold;
         txSb <= next_txSb;
      end
   end

   // ==========================================
   // receive side bring-up
   ssi_pkg::ssi_recv_state_t rcvState, next_rcvState;
   logic [`SSI_CNT_W-1:0] rcvCnt, next_rcvCnt;
   ssi_pkg::ssi_sideband_t next_rxSb;

   // watchdog covers aligned, bonded and verify so a silent sender cannot deadlock
   always_comb begin
      next_rcvState = rcvState;
      next_rcvCnt = rcvCnt + 1'h1;
      case (rcvState)
         ssi_pkg::RCV_RESET: begin
            if (rxLaneAligned) begin
               next_rcvState = ssi_pkg::RCV_ALIGNED;
            end
         end
         ssi_pkg::RCV_ALIGNED: begin
            if (!MULTI) begin
               next_rcvState = ssi_pkg::RCV_VERIFY;
            end else if (rxLaneBonded) begin
               next_rcvState = ssi_pkg::RCV_BONDED;
            end
         end
         ssi_pkg::RCV_BONDED: begin
            next_rcvState = ssi_pkg::RCV_VERIFY;
         end
         ssi_pkg::RCV_VERIFY: begin
            if (rxLaneVerified) begin
               next_rcvState = ssi_pkg::RCV_READY;
            end
         end
         ssi_pkg::RCV_READY: begin
            next_rcvState = ssi_pkg::RCV_READY;
         end
         default: begin
            next_rcvState = ssi_pkg::RCV_RESET;
         end
      endcase
      if (rcvState == ssi_pkg::RCV_RESET || rcvState == ssi_pkg::RCV_READY) begin
         next_rcvCnt = '0;
      end else if (rcvCnt == WATCHDOG_TIMEOUT - 1'h1) begin
         next_rcvState = ssi_pkg::RCV_RESET;
         next_rcvCnt = '0;
      end
      if (!rxLaneAligned) begin
         next_rcvState = ssi_pkg::RCV_RESET;
         next_rcvCnt = '0;
      end
      next_rxSb.reset = (next_rcvState == ssi_pkg::RCV_RESET);
      next_rxSb.aligned = (next_rcvState != ssi_pkg::RCV_RESET);
      next_rxSb.bonded = MULTI && (next_rcvState == ssi_pkg::RCV_BONDED ||
                                   next_rcvState == ssi_pkg::RCV_VERIFY ||
                                   next_rcvState == ssi_pkg::RCV_READY);
      next_rxSb.verify = (next_rcvState == ssi_pkg::RCV_VERIFY ||
                          next_rcvState == ssi_pkg::RCV_READY);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rcvState <= ssi_pkg::RCV_RESET;
         rcvCnt <= '0;
         link.rxSb <= 4'h8;
         rxReady <= 1'h0;
      end else begin
         rcvState <= next_rcvState;
         rcvCnt <= next_rcvCnt;
         link.rxSb <= next_rxSb;
         rxReady <= (next_rcvState == ssi_pkg::RCV_READY);
      end
   end

   // ==========================================
   // transceiver control and status
   // one register stage keeps every output on a flop; costs one cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         xcvrPowerDown <= 1'h0;
         xcvrLoopback <= 3'h0;
         txResetDone <= 1'h0;
         rxResetDone <= 1'h0;
         txLock <= 1'h0;
      end else begin
         xcvrPowerDown <= powerDown;
         xcvrLoopback <= loopback;
         txResetDone <= xcvrTxResetDone;
         rxResetDone <= xcvrRxResetDone;
         txLock <= xcvrPllLock;
      end
   end

   // ==========================================
   // reconfiguration slave
   logic [`SSI_DRP_DW-1:0] cfgMem [`SSI_DRP_DEPTH];
   logic [`SSI_DRP_DW-1:0] next_drpDo;
   logic next_drpRdy;
   logic inRange;

   // addresses past the small table read zero and drop writes
   always_comb begin
      inRange = (link.drpAddr < `SSI_DRP_AW'(`SSI_DRP_DEPTH));
      next_drpRdy = link.drpEn;
      next_drpDo = link.drpDo;
      if (link.drpEn && !link.drpWe) begin
         next_drpDo = inRange ? cfgMem[link.drpAddr[`SSI_DRP_IW-1:0]] : '0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `SSI_DRP_DEPTH; i++) begin
            cfgMem[i] <= `SSI_DRP_RST;
         end
         link.drpRdy <= 1'h0;
         link.drpDo <= '0;
      end else begin
         if (link.drpEn && link.drpWe && inRange) begin
            cfgMem[link.drpAddr[`SSI_DRP_IW-1:0]] <= link.drpDi;
         end
         link.drpRdy <= next_drpRdy;
         link.drpDo <= next_drpDo;
      end
   end

endmodule

// ### hdl/ssi_far_end.sv
// back channel forwarder and reconfiguration controller for the far party
`include "ssi_cfg.svh"

module ssi_far_end (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // sideband and reconfiguration link
   ssi_link_if.far link,
   // back channel status
   output logic msgSent,
   // reconfiguration requests
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [`SSI_DRP_AW-1:0] reqAddr,
   input wire logic [`SSI_DRP_DW-1:0] reqData,
   output logic reqBusy,
   output logic ackValid,
   output logic [`SSI_DRP_DW-1:0] ackData
);

   // ==========================================
   // back channel
   ssi_pkg::ssi_sideband_t lastSent, next_lastSent, next_txSbIn;
   logic [`SSI_BC_W-1:0] bcCnt, next_bcCnt;
   logic bcBusy, next_bcBusy;
   logic next_msgSent;

   // a change starts a message; it carries the set current at delivery
   always_comb begin
      next_lastSent = lastSent;
      next_txSbIn = link.txSbIn;
      next_bcCnt = bcCnt;
      next_bcBusy = bcBusy;
      next_msgSent = 1'h0;
      if (!bcBusy) begin
         if (link.rxSb != lastSent) begin
            next_bcBusy = 1'h1;
            next_bcCnt = '0;
         end
      end else if (bcCnt == `SSI_BC_W'(`SSI_BC_CYC - 1)) begin
         next_bcBusy = 1'h0;
         next_txSbIn = link.rxSb;
         next_lastSent = link.rxSb;
         next_msgSent = 1'h1;
      end else begin
         next_bcCnt = bcCnt + 1'h1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lastSent <= 4'h8;
         link.txSbIn <= 4'h8;
         bcCnt <= '0;
         bcBusy <= 1'h0;
         msgSent <= 1'h0;
      end else begin
         lastSent <= next_lastSent;
         link.txSbIn <= next_txSbIn;
         bcCnt <= next_bcCnt;
         bcBusy <= next_bcBusy;
         msgSent <= next_msgSent;
      end
   end

   // ==========================================
   // reconfiguration controller
   ssi_pkg::ssi_drpc_state_t drpcState, next_drpcState;
   logic [`SSI_DRP_AW-1:0] next_drpAddr;
   logic [`SSI_DRP_DW-1:0] next_drpDi, next_ackData;
   logic next_drpEn, next_drpWe, next_ackValid;

   // one access in flight; enable is a single-cycle strobe
   always_comb begin
      next_drpcState = drpcState;
      next_drpAddr = link.drpAddr;
      next_drpDi = link.drpDi;
      next_drpEn = 1'h0;
      next_drpWe = 1'h0;
      next_ackValid = 1'h0;
      next_ackData = ackData;
      case (drpcState)
         ssi_pkg::DRPC_IDLE: begin
            if (reqValid) begin
               next_drpAddr = reqAddr;
               next_drpDi = reqData;
               next_drpEn = 1'h1;
               next_drpWe = reqWrite;
               next_drpcState = ssi_pkg::DRPC_WAIT;
            end
         end
         ssi_pkg::DRPC_WAIT: begin
            if (link.drpRdy) begin
               next_ackValid = 1'h1;
               next_ackData = link.drpDo;
               next_drpcState = ssi_pkg::DRPC_IDLE;
            end
         end
         default: begin
            next_drpcState = ssi_pkg::DRPC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         drpcState <= ssi_pkg::DRPC_IDLE;
         link.drpAddr <= '0;
         link.drpDi <= '0;
         link.drpEn <= 1'h0;
         link.drpWe <= 1'h0;
         reqBusy <= 1'h0;
         ackValid <= 1'h0;
         ackData <= '0;
      end else begin
         drpcState <= next_drpcState;
         link.drpAddr <= next_drpAddr;
         link.drpDi <= next_drpDi;
         link.drpEn <= next_drpEn;
         link.drpWe <= next_drpWe;
         reqBusy <= (next_drpcState == ssi_pkg::DRPC_WAIT);
         ackValid <= next_ackValid;
         ackData <= next_ackData;
      end
   end

endmodule

// ### sim/ssi_link_assertions.sv
// concurrent checks on the link that joins the two ends
`include "ssi_cfg.svh"

module ssi_link_assertions (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // sideband sets
   input wire ssi_pkg::ssi_sideband_t rxSb,
   input wire ssi_pkg::ssi_sideband_t txSbIn,
   // reconfiguration port
   input wire logic [`SSI_DRP_AW-1:0] drpAddr,
   input wire logic [`SSI_DRP_DW-1:0] drpDi,
   input wire logic drpEn,
   input wire logic drpWe,
   input wire logic [`SSI_DRP_DW-1:0] drpDo,
   input wire logic drpRdy
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // staleness of the forwarded set
   // a change landing on a delivery edge costs a second message, hence twice the latency
   localparam int DELIVER_MAX = 2 * (`SSI_BC_CYC + 1) + 2;
   logic [5:0] staleCount;
   logic [5:0] next_staleCount;
   logic [3:0] lastRxSb;

   // count cycles that a steady receive set waits for delivery
   always_comb begin
      next_staleCount = 6'h00;
      if (rxSb != txSbIn && rxSb == lastRxSb && staleCount != 6'h3F) begin
         next_staleCount = staleCount + 6'h01;
      end
   end

   // register the count and the last receive set
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         staleCount <= 6'h00;
         lastRxSb <= 4'h8;
      end else begin
         staleCount <= next_staleCount;
         lastRxSb <= rxSb;
      end
   end

   // ==========================================
   // properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   // one access: answer next cycle, port quiet for the two cycles after the enable
   sequence accessWalk;
      ##1 (drpRdy && !drpEn) ##1 (!drpRdy && !drpEn);
   endsequence

   drp_access_walk_a: assert property (drpEn |-> accessWalk)
      else $error("reconfiguration access walk broken");
   ready_has_cause_a: assert property (drpRdy |-> $past(drpEn))
      else $error("ready without a preceding enable");
   read_data_hold_a: assert property ($changed(drpDo) |-> drpRdy && !$past(drpWe))
      else $error("read data moved outside a read answer");
   unmapped_read_a: assert property (drpRdy && !$past(drpWe) && ($past(drpAddr) >= 9'(`SSI_DRP_DEPTH))
      |-> drpDo == 16'h0000)
      else $error("unmapped read did not return zero");
   bc_payload_a: assert property ($changed(txSbIn) |-> txSbIn == $past(rxSb))
      else $error("forwarded set differs from receive set");
   bc_spacing_a: assert property ($changed(txSbIn) |=> $stable(txSbIn) [*8])
      else $error("back channel messages too close");
   bc_delivery_a: assert property (staleCount <= 6'(DELIVER_MAX))
      else $error("receive change not delivered in time");
   rx_reset_clean_a: assert property (rxSb.reset |-> rxSb[2:0] == 3'h0)
      else $error("reset indication mixed with progress");
   rx_stage_order_a: assert property (rxSb.verify |-> rxSb.aligned && (rxSb.bonded || `SSI_LANES == 1))
      else $error("verify without earlier stages");
endmodule

// ### sim/simplex_sideband_init_test.sv
// self-checking bench joining both ends of the simplex sideband initialization glue
`include "ssi_cfg.svh"

module simplex_sideband_init_test;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // sizes: reinit long enough to reach verify, watchdog kept short
   localparam int REINIT_N = 8000;
   localparam int T_BOND = `SSI_ALIGN_CYC + `SSI_BOND_CYC;
   localparam int T_VER = T_BOND + `SSI_VERIFY_CYC;
   int phaseAt [5] = '{`SSI_ALIGN_CYC / 2, T_BOND - 500, T_VER - 500, T_VER + 500, REINIT_N + 1000};
   logic [3:0] phaseSet [5] = '{4'h8, 4'h1, 4'h3, 4'h7, 4'h8};
   logic tWr [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
   logic [8:0] tAddr [7] = '{9'h000, 9'h00F, 9'h010, 9'h000, 9'h00F, 9'h010, 9'h005};
   logic [15:0] tData [7] = '{16'hA5C3, 16'h5A3C, 16'hFFFF, 16'hA5C3, 16'h5A3C, 16'h0000, 16'h0000};

   logic core_clk, arst_n, backChannelMode, rxLaneAligned, rxLaneBonded, rxLaneVerified, powerDown;
   logic xcvrTxResetDone, xcvrRxResetDone, xcvrPllLock, rxReady, xcvrPowerDown, txResetDone, rxResetDone, txLock;
   logic [`SSI_LOOP_W-1:0] loopback, xcvrLoopback;
   logic msgSent, reqValid, reqWrite, reqBusy, ackValid;
   logic [`SSI_DRP_AW-1:0] reqAddr;
   logic [`SSI_DRP_DW-1:0] reqData, ackData;
   ssi_pkg::ssi_sideband_t txSb;
   int cyc = 0;
   int fail_count = 0;
   int check_count = 0;

   // ==========================================
   // the two ends face each other across the carrier
   ssi_link_if u_ssi_link_if (.core_clk(core_clk), .arst_n(arst_n));
   ssi_dev_end #(.REINIT_CYCLES(`SSI_CNT_W'(REINIT_N)), .WATCHDOG_TIMEOUT(`SSI_CNT_W'(300))) u_ssi_dev_end (
      .core_clk(core_clk), .arst_n(arst_n), .link(u_ssi_link_if), .backChannelMode(backChannelMode),
      .rxLaneAligned(rxLaneAligned), .rxLaneBonded(rxLaneBonded), .rxLaneVerified(rxLaneVerified),
      .txSb(txSb), .rxReady(rxReady), .powerDown(powerDown), .loopback(loopback),
      .xcvrPowerDown(xcvrPowerDown), .xcvrLoopback(xcvrLoopback), .xcvrTxResetDone(xcvrTxResetDone),
      .xcvrRxResetDone(xcvrRxResetDone), .xcvrPllLock(xcvrPllLock), .txResetDone(txResetDone),
      .rxResetDone(rxResetDone), .txLock(txLock));
   ssi_far_end u_ssi_far_end (
      .core_clk(core_clk), .arst_n(arst_n), .link(u_ssi_link_if), .msgSent(msgSent), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqBusy(reqBusy), .ackValid(ackValid),
      .ackData(ackData));
   ssi_link_assertions u_ssi_link_assertions (
      .core_clk(core_clk), .arst_n(arst_n), .rxSb(u_ssi_link_if.rxSb), .txSbIn(u_ssi_link_if.txSbIn),
      .drpAddr(u_ssi_link_if.drpAddr), .drpDi(u_ssi_link_if.drpDi), .drpEn(u_ssi_link_if.drpEn),
      .drpWe(u_ssi_link_if.drpWe), .drpDo(u_ssi_link_if.drpDo), .drpRdy(u_ssi_link_if.drpRdy));

   // ==========================================
   // clock, cycle count since release, hang guard
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (arst_n) cyc <= cyc + 1;
   end

   // whole run is about 10k cycles, so twice that means a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      $display("[ERR] timeout expected finish seen hang");
      stop_test();
   end

   // ==========================================
   // helpers
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // settled value of an observed output, chosen by number
   function automatic logic [15:0] pick(input int sel);
      case (sel)
         0: return 16'(txSb);
         1: return 16'(u_ssi_link_if.rxSb);
         2: return 16'(u_ssi_link_if.txSbIn);
         3: return {15'h0000, ackValid};
         4: return {15'h0000, msgSent};
         default: return {15'h0000, rxReady};
      endcase
   endfunction

   // poll after each edge, bounded, then compare
   task automatic wait_for(input int sel, input logic [15:0] exp, input int maxc, input string name);
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (pick(sel) !== exp && n < maxc);
      check(name, exp, pick(sel));
   endtask

   // one reconfiguration access through the far controller
   task automatic access(input logic wr, input logic [8:0] addr, input logic [15:0] data);
      @(posedge core_clk);
      reqValid <= 1'b1;
      reqWrite <= wr;
      reqAddr <= addr;
      reqData <= data;
      @(posedge core_clk);
      reqValid <= 1'b0;
      #1;
      check("busy after take", 16'h0001, {15'h0000, reqBusy});
      wait_for(3, 16'h0001, 8, "ack");
      check("busy after ack", 16'h0000, {15'h0000, reqBusy});
      if (!wr) check("read data", data, ackData);
   endtask

   // ==========================================
   // main sequence
   initial begin
      {arst_n, backChannelMode, rxLaneAligned, rxLaneBonded, rxLaneVerified, powerDown} = '0;
      {xcvrTxResetDone, xcvrRxResetDone, xcvrPllLock, reqValid, reqWrite} = '0;
      loopback = '0;
      reqAddr = '0;
      reqData = '0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;

      // transceiver control and status pass one register stage
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         loopback <= 3'(i);
         powerDown <= i[0];
         xcvrTxResetDone <= i[1];
         xcvrRxResetDone <= i[2];
         xcvrPllLock <= ~i[0];
         @(posedge core_clk);
         #1;
         check("loopback", 16'(i), 16'(xcvrLoopback));
         check("power down", 16'(i[0]), 16'(xcvrPowerDown));
         check("status", 16'({i[1], i[2], ~i[0]}), 16'({txResetDone, rxResetDone, txLock}));
      end
      $display("test passthrough done");

      // writes incl. one unmapped, then reads back incl. unmapped and untouched words
      for (int k = 0; k < 7; k++) access(tWr[k], tAddr[k], tData[k]);
      $display("test reconfiguration done");

      // receive bring-up, watchdog and forwarding while the send side runs on timers
      @(posedge core_clk);
      rxLaneAligned <= 1'b1;
      wait_for(1, 16'h0001, 4, "rx aligned");
      wait_for(2, 16'h0001, 16, "forwarded aligned");
      wait_for(1, 16'h0008, 320, "rx watchdog");
      @(posedge core_clk);
      rxLaneBonded <= 1'b1;
      rxLaneVerified <= 1'b1;
      wait_for(5, 16'h0001, 10, "rx ready");
      check("rx ready set", 16'h0007, pick(1));
      wait_for(2, 16'h0007, 30, "forwarded ready");
      check("timed send ignores channel", 16'h0008, pick(0));
      repeat (400) @(posedge core_clk);
      #1;
      check("ready survives watchdog", 16'h0001, pick(5));
      @(posedge core_clk);
      rxLaneAligned <= 1'b0;
      wait_for(1, 16'h0008, 3, "rx drop");
      wait_for(4, 16'h0001, 16, "message pulse");
      check("forwarded drop", 16'h0008, pick(2));
      $display("test receive done");

      // timed send side order and periodic restart
      for (int k = 0; k < 5; k++) begin
         while (cyc < phaseAt[k]) @(posedge core_clk);
         #1;
         check("timed send set", 16'(phaseSet[k]), pick(0));
      end
      $display("test timers done");

      // send side follows the back channel, then its own watchdog
      @(posedge core_clk);
      backChannelMode <= 1'b1;
      rxLaneAligned <= 1'b1;
      wait_for(0, 16'h0007, 40, "send follows ready");
      @(posedge core_clk);
      rxLaneAligned <= 1'b0;
      wait_for(0, 16'h0008, 20, "send follows reset");
      @(posedge core_clk);
      {rxLaneAligned, rxLaneBonded, rxLaneVerified} <= 3'h4;
      wait_for(0, 16'h0001, 20, "send follows aligned");
      wait_for(0, 16'h0008, 320, "send watchdog");
      // forwarded set still says aligned, so only the hold keeps the send side down
      repeat (5) @(posedge core_clk);
      #1;
      check("send hold", 16'h0008, pick(0));
      $display("test back channel done");
      stop_test();
   end
endmodule
